//--- core/pfpw_pkg.sv
// package: register map, field positions, reset values and timing constants for the power/wake block
package pfpw_pkg;

	// ----------------------------------------------------------------
	// register word offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_LOCAL_CONFIG_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_LOCAL_BUS_TIMING     = 8'h04;
	localparam logic [7:0] ADDR_MULTIPURPOSE_IO_CFG  = 8'h08;
	localparam logic [7:0] ADDR_GLOBAL_INT_STATUS    = 8'h0C;
	localparam logic [7:0] ADDR_PM_CSR               = 8'h10;
	localparam logic [7:0] ADDR_EVENT_STATUS         = 8'h14;
	localparam logic [7:0] ADDR_EVENT_MASK           = 8'h18;
	localparam logic [7:0] ADDR_PDOWN_INPUT          = 8'h1C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LCC_CLK_OUT_EN_BIT = 2;
	localparam int LCC_FILTER_LO_BIT  = 5;
	localparam int LCC_WAKE_EN_BIT    = 7;
	localparam int LT2_LB_CLK_EN_BIT  = 30;
	localparam int MIC_WAKE_SENSE_BIT = 4;
	localparam int MIC_WAKE_DIR_BIT   = 5;
	localparam int GIS_PIN1_STAT_BIT  = 5;
	localparam int GIS_PIN1_MASK_BIT  = 21;
	localparam int PMCSR_STATE_LO_BIT = 0;
	localparam int PMCSR_PME_EN_BIT   = 8;
	localparam int PMCSR_PME_STAT_BIT = 15;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_LOCAL_CONFIG_CONTROL = 32'h0000_0000;
	localparam logic [31:0] RST_LOCAL_BUS_TIMING     = 32'h0000_0000;
	localparam logic [31:0] RST_MULTIPURPOSE_IO_CFG  = 32'h0000_0000;
	localparam logic [2:0]  RST_EVENT_MASK           = 3'h0;

	// ----------------------------------------------------------------
	// power states and filter codes
	// ----------------------------------------------------------------
	localparam logic [1:0] PSTATE_D0 = 2'h0;
	localparam logic [1:0] PSTATE_D2 = 2'h2;
	localparam logic [1:0] PSTATE_D3 = 2'h3;

	localparam logic [1:0] FILTER_OFF  = 2'h0;
	localparam logic [1:0] FILTER_4S   = 2'h1;
	localparam logic [1:0] FILTER_129S = 2'h2;
	localparam logic [1:0] FILTER_518S = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint CLK_HZ       = 250_000_000;
	localparam longint FILTER_A_S   = 4;
	localparam longint FILTER_B_S   = 129;
	localparam longint FILTER_C_S   = 518;
	localparam longint FILTER_A_CYC = FILTER_A_S * CLK_HZ;
	localparam longint FILTER_B_CYC = FILTER_B_S * CLK_HZ;
	localparam longint FILTER_C_CYC = FILTER_C_S * CLK_HZ;

	// ----------------------------------------------------------------
	// event bit positions in the event status/mask registers
	// ----------------------------------------------------------------
	localparam int EV_WAKE  = 0;
	localparam int EV_PDOWN = 1;
	localparam int EV_PIN1  = 2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} pfpw_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} pfpw_wb_rsp_t;

	typedef struct packed {
		logic serial_clk_en;
		logic local_bus_clk_en;
		logic func_irq_en;
		logic bar_access_en;
	} pfpw_gate_t;

endpackage : pfpw_pkg

//--- core/pfpw_top.sv
// power management and wake-up logic of the local bus function, plus serial power-down filter decode
//
// Operation
// - D0, D2, D3 supported; D2/D3 low power
// - low power forces serial clock output off
// - low power forces local bus clock off
// - low power suppresses function interrupt
// - low power blocks BAR accesses, config served
// - wake edge sets PME status when enabled
// - sense bit picks rising or falling edge
// - wake enable forces pin two to input
// - PME status sticky, write one clears
// - PME enable and status drive PME low
// - filter code selects 4, 129, 518 seconds
// - filter off: pin one interrupt allowed
// - filter on, mask clear: polling only
// - filter on, mask set: power-down interrupt
// - PME released only when serial status clear and PME status or enable clear
`timescale 1ns/1ps

module pfpw_top #(
	parameter longint FILTER_A_CYC = pfpw_pkg::FILTER_A_CYC,
	parameter longint FILTER_B_CYC = pfpw_pkg::FILTER_B_CYC,
	parameter longint FILTER_C_CYC = pfpw_pkg::FILTER_C_CYC
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// wishbone slave
	input  wire pfpw_pkg::pfpw_wb_req_t wb_req_i,
	output pfpw_pkg::pfpw_wb_rsp_t      wb_rsp_o,
	// wake pin (two-way)
	input  wire logic                   wake_input_pin_i,
	input  wire logic                   wake_pin_out_val_i,
	output logic                        wake_input_pin_o,
	output logic                        wake_input_pin_oe_o,
	// pins and internal sources
	input  wire logic                   multipurpose_pin_one_i,
	input  wire logic                   serial_inactive_i,
	input  wire logic                   serial_pme_status_i,
	input  wire logic                   func_irq_req_i,
	input  wire logic                   bar_access_req_i,
	input  wire logic [9:0]             spare_multipurpose_pins_i,
	// gated outputs
	output pfpw_pkg::pfpw_gate_t        gate_o,
	output logic                        serial_clk_out_o,
	output logic                        local_bus_clock_pin_o,
	output logic                        func_irq_o,
	output logic                        bar_access_grant_o,
	output logic                        serial_pdown_irq_o,
	output logic                        pin_one_irq_o,
	output logic                        pme_n_o,
	output logic                        irq_o
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] local_config_control_ff;
	logic [31:0] local_bus_timing_second_ff;
	logic [31:0] multipurpose_io_config_ff;
	logic [1:0]  power_state_ff;
	logic        pme_en_ff;
	logic        pme_status_ff;
	logic        pdown_sticky_ff;
	logic [2:0]  ev_status_ff;
	logic [2:0]  ev_mask_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  wake_sync_ff;
	logic        wake_prev_ff;
	logic [1:0]  pin1_sync_ff;
	logic [1:0]  inact_sync_ff;
	logic [9:0]  spare_s1_ff;
	logic [9:0]  spare_s2_ff;
	logic [39:0] filt_cnt_ff;
	logic        pdown_state_ff;
	logic        clk_div_ff;
	logic        pme_n_ff;

	logic        low_power, wake_en, gis_mask;
	logic [1:0]  filter_sel;
	logic        wr_stb, rd_stb;
	logic        wake_rise, wake_fall, wake_event, pdown_rise;
	logic [39:0] filt_limit;
	logic [31:0] nxt_rdata, gis_word, pmcsr_word;

	// ----------------------------------------------------------------
	// power state decode
	// ----------------------------------------------------------------
	assign low_power  = (power_state_ff == pfpw_pkg::PSTATE_D2) ||
	                    (power_state_ff == pfpw_pkg::PSTATE_D3);
	assign wake_en    = local_config_control_ff[pfpw_pkg::LCC_WAKE_EN_BIT];
	assign filter_sel = local_config_control_ff[pfpw_pkg::LCC_FILTER_LO_BIT +: 2];
	assign gis_mask   = multipurpose_io_config_ff[31];

	// ----------------------------------------------------------------
	// wishbone slave: one wait state, ack one cycle
	// ----------------------------------------------------------------
	assign wr_stb = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_ff;
	assign rd_stb = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~ack_ff;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
	end
	assign gis_word = {10'h000, gis_mask, 15'h0000, pdown_sticky_ff, 5'h00};
	assign pmcsr_word = {16'h0000, pme_status_ff, 6'h00, pme_en_ff, 6'h00, power_state_ff};
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		unique case (wb_req_i.adr)
			pfpw_pkg::ADDR_LOCAL_CONFIG_CONTROL: nxt_rdata = local_config_control_ff;
			pfpw_pkg::ADDR_LOCAL_BUS_TIMING:     nxt_rdata = local_bus_timing_second_ff;
			pfpw_pkg::ADDR_MULTIPURPOSE_IO_CFG:  nxt_rdata = multipurpose_io_config_ff;
			pfpw_pkg::ADDR_GLOBAL_INT_STATUS:    nxt_rdata = gis_word;
			pfpw_pkg::ADDR_PM_CSR:               nxt_rdata = pmcsr_word;
			pfpw_pkg::ADDR_EVENT_STATUS:         nxt_rdata = {29'h0000_0000, ev_status_ff};
			pfpw_pkg::ADDR_EVENT_MASK:           nxt_rdata = {29'h0000_0000, ev_mask_ff};
			pfpw_pkg::ADDR_PDOWN_INPUT:          nxt_rdata = {22'h00_0000, spare_s2_ff};
			default:                             nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_ff <= 32'h0000_0000;
		else if (rd_stb)
			rdata_ff <= nxt_rdata;
	end
	assign wb_rsp_o.ack = ack_ff;
	assign wb_rsp_o.dat = rdata_ff;
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		merge = r;
	endfunction : merge

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			local_config_control_ff    <= pfpw_pkg::RST_LOCAL_CONFIG_CONTROL;
			local_bus_timing_second_ff <= pfpw_pkg::RST_LOCAL_BUS_TIMING;
			multipurpose_io_config_ff  <= pfpw_pkg::RST_MULTIPURPOSE_IO_CFG;
			ev_mask_ff                 <= pfpw_pkg::RST_EVENT_MASK;
		end
		else if (wr_stb)
		begin
			unique case (wb_req_i.adr)
				pfpw_pkg::ADDR_LOCAL_CONFIG_CONTROL:
					local_config_control_ff <= merge(local_config_control_ff, wb_req_i.dat, wb_req_i.sel);
				pfpw_pkg::ADDR_LOCAL_BUS_TIMING:
					local_bus_timing_second_ff <= merge(local_bus_timing_second_ff, wb_req_i.dat, wb_req_i.sel);
				pfpw_pkg::ADDR_MULTIPURPOSE_IO_CFG:
					multipurpose_io_config_ff <= merge(multipurpose_io_config_ff, wb_req_i.dat, wb_req_i.sel);
				pfpw_pkg::ADDR_GLOBAL_INT_STATUS:
					if (wb_req_i.sel[2])
						multipurpose_io_config_ff[31] <= wb_req_i.dat[pfpw_pkg::GIS_PIN1_MASK_BIT];
				pfpw_pkg::ADDR_EVENT_MASK:
					if (wb_req_i.sel[0])
						ev_mask_ff <= wb_req_i.dat[2:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// power management control/status
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			power_state_ff <= pfpw_pkg::PSTATE_D0;
			pme_en_ff      <= 1'b0;
		end
		else if (wr_stb && wb_req_i.adr == pfpw_pkg::ADDR_PM_CSR)
		begin
			if (wb_req_i.sel[0] && wb_req_i.dat[1:0] != 2'h1)
				power_state_ff <= wb_req_i.dat[1:0];
			if (wb_req_i.sel[1])
				pme_en_ff <= wb_req_i.dat[pfpw_pkg::PMCSR_PME_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// wake pin sync and edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wake_sync_ff  <= 2'h0;
			wake_prev_ff  <= 1'b0;
			pin1_sync_ff  <= 2'h0;
			inact_sync_ff <= 2'h0;
			spare_s1_ff   <= 10'h000;
			spare_s2_ff   <= 10'h000;
		end
		else
		begin
			wake_sync_ff  <= {wake_sync_ff[0], wake_input_pin_i};
			wake_prev_ff  <= wake_sync_ff[1];
			pin1_sync_ff  <= {pin1_sync_ff[0], multipurpose_pin_one_i};
			inact_sync_ff <= {inact_sync_ff[0], serial_inactive_i};
			spare_s1_ff   <= spare_multipurpose_pins_i;
			spare_s2_ff   <= spare_s1_ff;
		end
	end

	assign wake_rise  = wake_sync_ff[1] & ~wake_prev_ff;
	assign wake_fall  = ~wake_sync_ff[1] & wake_prev_ff;
	assign wake_event = wake_en & pme_en_ff &
	                    (multipurpose_io_config_ff[pfpw_pkg::MIC_WAKE_SENSE_BIT] ? wake_fall : wake_rise);
	// pin is held input while wake is enabled
	assign wake_input_pin_o    = wake_pin_out_val_i;
	assign wake_input_pin_oe_o = multipurpose_io_config_ff[pfpw_pkg::MIC_WAKE_DIR_BIT] & ~wake_en;

	// ----------------------------------------------------------------
	// sticky PME status, set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pme_status_ff <= 1'b0;
		else if (wake_event)
			pme_status_ff <= 1'b1;
		else if (wr_stb && wb_req_i.adr == pfpw_pkg::ADDR_PM_CSR && wb_req_i.sel[1] &&
		         wb_req_i.dat[pfpw_pkg::PMCSR_PME_STAT_BIT])
			pme_status_ff <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pme_n_ff <= 1'b1;
		else
			pme_n_ff <= ~((pme_en_ff & pme_status_ff) | serial_pme_status_i);
	end
	assign pme_n_o = pme_n_ff;

	// ----------------------------------------------------------------
	// serial power-down filter
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (filter_sel)
			pfpw_pkg::FILTER_4S:   filt_limit = 40'(FILTER_A_CYC);
			pfpw_pkg::FILTER_129S: filt_limit = 40'(FILTER_B_CYC);
			pfpw_pkg::FILTER_518S: filt_limit = 40'(FILTER_C_CYC);
			pfpw_pkg::FILTER_OFF:  filt_limit = 40'h00_0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			filt_cnt_ff    <= 40'h00_0000_0000;
			pdown_state_ff <= 1'b0;
		end
		else if (filter_sel == pfpw_pkg::FILTER_OFF || !inact_sync_ff[1])
		begin
			filt_cnt_ff    <= 40'h00_0000_0000;
			pdown_state_ff <= 1'b0;
		end
		else if (filt_cnt_ff >= filt_limit - 40'h00_0000_0001)
			pdown_state_ff <= 1'b1;
		else
			filt_cnt_ff <= filt_cnt_ff + 40'h00_0000_0001;
	end

	assign pdown_rise = inact_sync_ff[1] && filter_sel != pfpw_pkg::FILTER_OFF && !pdown_state_ff &&
	                    filt_cnt_ff >= filt_limit - 40'h00_0000_0001;
	// sticky power-down status, cleared by reading it; tracks pin one while the filter is off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pdown_sticky_ff <= 1'b0;
		else if (filter_sel == pfpw_pkg::FILTER_OFF)
			pdown_sticky_ff <= pin1_sync_ff[1];
		else if (pdown_rise)
			pdown_sticky_ff <= 1'b1;
		else if (rd_stb && wb_req_i.adr == pfpw_pkg::ADDR_GLOBAL_INT_STATUS)
			pdown_sticky_ff <= 1'b0;
	end

	assign serial_pdown_irq_o = (filter_sel != pfpw_pkg::FILTER_OFF) & gis_mask & pdown_sticky_ff;
	assign pin_one_irq_o      = (filter_sel == pfpw_pkg::FILTER_OFF) & gis_mask & pin1_sync_ff[1];

	// ----------------------------------------------------------------
	// low-power gating
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			clk_div_ff <= 1'b0;
		else
			clk_div_ff <= ~clk_div_ff;
	end

	assign gate_o.serial_clk_en    = local_config_control_ff[pfpw_pkg::LCC_CLK_OUT_EN_BIT] & ~low_power;
	assign gate_o.local_bus_clk_en = local_bus_timing_second_ff[pfpw_pkg::LT2_LB_CLK_EN_BIT] & ~low_power;
	assign gate_o.func_irq_en      = ~low_power;
	assign gate_o.bar_access_en    = ~low_power;
	assign serial_clk_out_o      = clk_div_ff & gate_o.serial_clk_en;
	assign local_bus_clock_pin_o = clk_div_ff & gate_o.local_bus_clk_en;
	assign func_irq_o            = func_irq_req_i & ~low_power;
	assign bar_access_grant_o    = bar_access_req_i & ~low_power;

	// ----------------------------------------------------------------
	// block interrupt: sticky events, cleared on read
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ev_status_ff <= 3'h0;
		else
			ev_status_ff <= ({3{~(rd_stb && wb_req_i.adr == pfpw_pkg::ADDR_EVENT_STATUS)}} & ev_status_ff) |
			                {pin1_sync_ff[1], pdown_rise, wake_event};
	end

	assign irq_o = |(ev_status_ff & ev_mask_ff);

endmodule : pfpw_top

//--- bench/pfpw_top_props.sv
// checker: bus handshake, low-power gating and PME relations of the power/wake block
`timescale 1ns/1ps

module pfpw_top_props #(
	parameter longint FILTER_A_CYC = 20,
	parameter longint FILTER_B_CYC = 40,
	parameter longint FILTER_C_CYC = 80
) (
	// clock and reset
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	// bus
	input wire pfpw_pkg::pfpw_wb_req_t wb_req_i,
	input wire pfpw_pkg::pfpw_wb_rsp_t wb_rsp_o,
	// sources
	input wire logic                   serial_pme_status_i,
	input wire logic                   func_irq_req_i,
	input wire logic                   bar_access_req_i,
	// outputs
	input wire pfpw_pkg::pfpw_gate_t   gate_o,
	input wire logic                   serial_clk_out_o,
	input wire logic                   local_bus_clock_pin_o,
	input wire logic                   func_irq_o,
	input wire logic                   bar_access_grant_o,
	input wire logic                   serial_pdown_irq_o,
	input wire logic                   pin_one_irq_o,
	input wire logic                   pme_n_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_take;
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	endsequence
	sequence s_answer;
		wb_rsp_o.ack ##1 !wb_rsp_o.ack;
	endsequence

	a_bus_ack_pulse: assert property (s_take |=> s_answer)
		else $error("ack not a single pulse after request");
	a_ack_has_req: assert property ($rose(wb_rsp_o.ack) |-> $past(wb_req_i.cyc && wb_req_i.stb))
		else $error("ack without request");
	a_func_irq_gated: assert property (func_irq_o == (func_irq_req_i && gate_o.func_irq_en))
		else $error("function interrupt not gated");
	a_bar_gated: assert property (bar_access_grant_o == (bar_access_req_i && gate_o.bar_access_en))
		else $error("bar access not gated");
	a_sclk_off: assert property (!gate_o.serial_clk_en |-> !serial_clk_out_o)
		else $error("serial clock runs while disabled");
	a_lbclk_off: assert property (!gate_o.local_bus_clk_en |-> !local_bus_clock_pin_o)
		else $error("local bus clock runs while disabled");
	a_sclk_runs: assert property (gate_o.serial_clk_en && $past(gate_o.serial_clk_en) |->
		serial_clk_out_o != $past(serial_clk_out_o))
		else $error("serial clock output stuck while enabled");
	a_lbclk_runs: assert property (gate_o.local_bus_clk_en && $past(gate_o.local_bus_clk_en) |->
		local_bus_clock_pin_o != $past(local_bus_clock_pin_o))
		else $error("local bus clock stuck while enabled");
	a_low_power_same: assert property (gate_o.func_irq_en == gate_o.bar_access_en)
		else $error("low-power gates disagree");
	a_pme_other: assert property (serial_pme_status_i |=> !pme_n_o)
		else $error("other function request not on pme");
	a_pme_release: assert property ($rose(pme_n_o) |-> !$past(serial_pme_status_i))
		else $error("pme released while other function requests");
	a_irq_exclusive: assert property (!(serial_pdown_irq_o && pin_one_irq_o))
		else $error("pin one and power-down interrupts both on");
endmodule : pfpw_top_props

bind pfpw_top pfpw_top_props #(
	.FILTER_A_CYC(FILTER_A_CYC),
	.FILTER_B_CYC(FILTER_B_CYC),
	.FILTER_C_CYC(FILTER_C_CYC)
) pfpw_top_props_inst (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_req_i(wb_req_i),
	.wb_rsp_o(wb_rsp_o),
	.serial_pme_status_i(serial_pme_status_i),
	.func_irq_req_i(func_irq_req_i),
	.bar_access_req_i(bar_access_req_i),
	.gate_o(gate_o),
	.serial_clk_out_o(serial_clk_out_o),
	.local_bus_clock_pin_o(local_bus_clock_pin_o),
	.func_irq_o(func_irq_o),
	.bar_access_grant_o(bar_access_grant_o),
	.serial_pdown_irq_o(serial_pdown_irq_o),
	.pin_one_irq_o(pin_one_irq_o),
	.pme_n_o(pme_n_o)
);

//--- bench/pfpw_board_model.sv
// partner: board-side pin sources and wake pin resolution
`timescale 1ns/1ps

module pfpw_board_model (
	// commands
	input  wire logic  wake_level_i,
	input  wire logic  pdown_req_i,
	// device pin side
	input  wire logic  dev_oe_i,
	input  wire logic  dev_out_i,
	output logic       wake_pin_o,
	output logic [9:0] spare_pins_o
);
	// device owns the pin only while it drives it
	assign wake_pin_o   = dev_oe_i ? dev_out_i : wake_level_i;
	// driver flags power-down on the spare lines
	assign spare_pins_o = pdown_req_i ? 10'h2A5 : 10'h15A;
endmodule : pfpw_board_model

//--- bench/testbench.sv
// testbench: register-driven checks of low-power gating, wake detection and filter decode
`timescale 1ns/1ps

module testbench;
	localparam int FA = 20;
	localparam int FB = 40;
	localparam int FC = 80;
	localparam logic [7:0] A_LCC = pfpw_pkg::ADDR_LOCAL_CONFIG_CONTROL;
	localparam logic [7:0] A_LT2 = pfpw_pkg::ADDR_LOCAL_BUS_TIMING;
	localparam logic [7:0] A_MIC = pfpw_pkg::ADDR_MULTIPURPOSE_IO_CFG;
	localparam logic [7:0] A_GIS = pfpw_pkg::ADDR_GLOBAL_INT_STATUS;
	localparam logic [7:0] A_PM  = pfpw_pkg::ADDR_PM_CSR;
	localparam logic [7:0] A_EVS = pfpw_pkg::ADDR_EVENT_STATUS;
	localparam logic [7:0] A_EVM = pfpw_pkg::ADDR_EVENT_MASK;
	localparam logic [7:0] A_SP  = pfpw_pkg::ADDR_PDOWN_INPUT;

	logic                   clk_i;
	logic                   rst_i    = 1'b1;
	pfpw_pkg::pfpw_wb_req_t req      = '0;
	pfpw_pkg::pfpw_wb_rsp_t rsp;
	pfpw_pkg::pfpw_gate_t   gate_o;
	logic                   wake_lvl = 1'b0;
	logic                   pdown    = 1'b0;
	logic                   out_val  = 1'b1;
	logic                   pin1     = 1'b0;
	logic                   inactive = 1'b0;
	logic                   spme     = 1'b0;
	logic                   firq     = 1'b0;
	logic                   bar      = 1'b0;
	logic                   pin, pin_o, oe, func_irq_o, bar_access_grant_o;
	logic                   serial_pdown_irq_o, pin_one_irq_o, pme_n_o, irq_o;
	logic [9:0]             spare;
	int                     mismatches  = 0;
	int                     comparisons = 0;

	pfpw_top #(.FILTER_A_CYC(FA), .FILTER_B_CYC(FB), .FILTER_C_CYC(FC)) pfpw_top_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
		.wake_input_pin_i(pin), .wake_pin_out_val_i(out_val), .wake_input_pin_o(pin_o),
		.wake_input_pin_oe_o(oe), .multipurpose_pin_one_i(pin1), .serial_inactive_i(inactive),
		.serial_pme_status_i(spme), .func_irq_req_i(firq), .bar_access_req_i(bar),
		.spare_multipurpose_pins_i(spare), .gate_o(gate_o), .serial_clk_out_o(),
		.local_bus_clock_pin_o(), .func_irq_o(func_irq_o), .bar_access_grant_o(bar_access_grant_o),
		.serial_pdown_irq_o(serial_pdown_irq_o), .pin_one_irq_o(pin_one_irq_o),
		.pme_n_o(pme_n_o), .irq_o(irq_o));

	pfpw_board_model pfpw_board_model_inst (
		.wake_level_i(wake_lvl), .pdown_req_i(pdown), .dev_oe_i(oe),
		.dev_out_i(pin_o), .wake_pin_o(pin), .spare_pins_o(spare));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: d};
		do
			@(posedge clk_i);
		while (rsp.ack !== 1'b1);
		q = rsp.dat;
		req <= '0;
		#1;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		bus(1'b1, a, d, s, q);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		chk(q, e);
	endtask : rd

	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step

	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		logic [7:0] ra [8] = '{A_LCC, A_LT2, A_MIC, A_GIS, A_PM, A_EVS, A_EVM, 8'h40};
		logic [1:0] ps [5] = '{pfpw_pkg::PSTATE_D2, 2'h1, pfpw_pkg::PSTATE_D0, pfpw_pkg::PSTATE_D3, 2'h0};
		logic [4:0] wk [6] = '{5'b11011, 5'b11000, 5'b11101, 5'b11110, 5'b01010, 5'b10010};
		logic [2:0] ft [5] = '{3'b011, 3'b101, 3'b111, 3'b010, 3'b001};
		int         fl [3] = '{FA, FB, FC};
		logic [1:0] st, c;
		logic       w, e, s, r, x, m;
		int         n;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[i]) rd(ra[i], 32'h0);
		@(posedge clk_i) firq <= 1'b1;
		bar <= 1'b1;
		wr(A_LCC, 32'h4, 4'hF);
		wr(A_LT2, 32'h4000_0000, 4'hF);
		st = 2'h0;
		for (int i = 0; i < 5; i++)
		begin
			wr(A_PM, {30'h0, ps[i]}, 4'h1);
			if (ps[i] != 2'h1)
				st = ps[i];
			rd(A_PM, {30'h0, st});
			chk(gate_o, (st != 2'h0) ? 4'h0 : 4'hF);
			chk(func_irq_o, st == 2'h0);
			chk(bar_access_grant_o, st == 2'h0);
		end
		wr(A_MIC, 32'h20, 4'hF);
		chk(oe, 1'b1);
		chk(pin_o, 1'b1);
		wr(A_LCC, 32'h84, 4'hF);
		chk(oe, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			{w, e, s, r, x} = wk[i];
			wr(A_LCC, 32'h4, 4'hF);
			@(posedge clk_i) wake_lvl <= !r;
			step(6);
			wr(A_MIC, {27'h0, s, 4'h0}, 4'hF);
			wr(A_LCC, {24'h0, w, 7'h04}, 4'hF);
			wr(A_PM, {23'h0, e, 8'h0}, 4'h2);
			@(posedge clk_i) wake_lvl <= r;
			step(8);
			rd(A_PM, {16'h0, x, 6'h0, e, 8'h0});
			chk(pme_n_o, !x);
			if (i == 0)
			begin
				chk(irq_o, 1'b0);
				wr(A_EVM, 32'h1, 4'hF);
				chk(irq_o, 1'b1);
				rd(A_EVS, 32'h1);
				chk(irq_o, 1'b0);
				wr(A_EVM, 32'h0, 4'hF);
			end
			@(posedge clk_i) spme <= (i == 0);
			wr(A_PM, {23'h0, e, 8'h0}, 4'h2);
			rd(A_PM, {16'h0, x, 6'h0, e, 8'h0});
			wr(A_PM, {16'h0, 1'b1, 6'h0, e, 8'h0}, 4'h2);
			rd(A_PM, {23'h0, e, 8'h0});
			chk(pme_n_o, i != 0);
			@(posedge clk_i) spme <= 1'b0;
			step(3);
			chk(pme_n_o, 1'b1);
		end
		for (int i = 0; i < 5; i++)
		begin
			{c, m} = ft[i];
			n = (c == 2'h0) ? FA : fl[c - 2'h1];
			wr(A_LCC, {25'h0, c, 5'h04}, 4'hF);
			wr(A_GIS, {10'h0, m, 21'h0}, 4'hF);
			@(posedge clk_i) inactive <= 1'b1;
			pin1 <= (c == 2'h0);
			step(n);
			chk(serial_pdown_irq_o, 1'b0);
			step(n);
			chk(serial_pdown_irq_o, m && c != 2'h0);
			chk(pin_one_irq_o, m && c == 2'h0);
			@(posedge clk_i) inactive <= 1'b0;
			pin1 <= 1'b0;
			if (c != 2'h0)
			begin
				rd(A_GIS, {10'h0, m, 15'h0, 1'b1, 5'h0});
				rd(A_GIS, {10'h0, m, 21'h0});
			end
		end
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk_i) pdown <= i[0];
			step(6);
			rd(A_SP, i[0] ? 32'h2A5 : 32'h15A);
		end
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		final_report();
	end
endmodule : testbench
